// file: pkg/isr_params.svh
// Purpose: constants of the status reporting block
// Assumes: included by the package file, compiled ahead of the design files
// Notes: bit positions follow the status register layouts
`ifndef ISR_PARAMS_SVH
`define ISR_PARAMS_SVH

// ==========================================
// reset values
`define ISR_ESR_RESET 8'h80
`define ISR_ESE_RESET 8'h00
`define ISR_SRE_RESET 8'h00

// ==========================================
// field positions
`define ISR_ESR_OPC 0
`define ISR_ESR_PON 7
`define ISR_STB_OSS 7
`define ISR_STB_RQS 6
`define ISR_STB_ESS 5
`define ISR_STB_MAV 4

// ==========================================
// reply encoding and counts
`define ISR_ASCII_NL 8'h0A
`define ISR_ASCII_ZERO 8'h30
`define ISR_OPC_REPLY 16'h0001
`define ISR_DIGITS 5
`define ISR_LAST_DIGIT 3'h4

`endif

// file: pkg/isr_pkg.sv
// Purpose: types of the status reporting block
// Assumes: isr_params.svh on the include path
// Notes: all state of each design module is one struct
`include "isr_params.svh"
package isr_pkg;

  typedef enum logic [3:0] {
    ISR_CMD_RST = 4'h0, ISR_CMD_TRG = 4'h1, ISR_CMD_IDN_Q = 4'h2, ISR_CMD_TST_Q = 4'h3,
    ISR_CMD_ESE = 4'h4, ISR_CMD_ESE_Q = 4'h5, ISR_CMD_SRE = 4'h6, ISR_CMD_SRE_Q = 4'h7,
    ISR_CMD_ESR_Q = 4'h8, ISR_CMD_STB_Q = 4'h9, ISR_CMD_OPC = 4'hA, ISR_CMD_OPC_Q = 4'hB,
    ISR_CMD_CLS = 4'hC
  } isr_cmd_t;

  typedef enum logic [1:0] {
    ISR_ST_IDLE = 2'b00, ISR_ST_MEAS = 2'b01, ISR_ST_TEST = 2'b10, ISR_ST_OPCQ = 2'b11
  } isr_state_t;

  typedef enum logic [1:0] {
    ISR_FMT_IDLE = 2'b00, ISR_FMT_CONV = 2'b01, ISR_FMT_SEND = 2'b10
  } isr_fmt_phase_t;

  typedef struct packed {
    isr_state_t state;
    logic [7:0] ese;
    logic [7:0] esr;
    logic [7:0] sre;
    logic [7:0] stb;
    logic opc_armed;
    logic inst_reset;
    logic meas_start;
    logic test_start;
    logic fmt_start;
    logic fmt_idn;
    logic [15:0] fmt_value;
  } isr_top_t;

  typedef struct packed {
    isr_fmt_phase_t phase;
    logic is_idn;
    logic lead;
    logic [15:0] val;
    logic [`ISR_DIGITS-1:0][3:0] digits;
    logic [2:0] cnt;
    logic [5:0] pos;
    logic [7:0] data;
    logic valid;
    logic eoi;
  } isr_fmt_t;

endpackage : isr_pkg

// file: rtl/isr_dec_fmt.sv
// Purpose: reply formatter, decimal integer or identity string, then newline with end
// Assumes: one reply at a time; start only while busy is low
// Notes: conversion takes five cycles, leading zeros are skipped
`timescale 1ns/100ps
module isr_dec_fmt
  import isr_pkg::*;
#(
  parameter int IDN_LEN = 27,
  // arbitrary neutral identity text, not any real part's
  parameter logic [8*IDN_LEN-1:0] IDN_STR = "MAKER0,MODEL0,FW0,HW0,DATE0"
) (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic start, // one-cycle start pulse
  input wire logic is_idn, // send identity text instead of a number
  input wire logic [15:0] value, // number to send
  output logic busy, // reply in progress
  output logic [7:0] rsp_data, // reply byte
  output logic rsp_eoi, // end marker with the last byte
  output logic rsp_valid, // reply byte valid
  input wire logic rsp_ready // reply byte taken
);

  isr_fmt_t r;
  isr_fmt_t next_r;
  logic [3:0] dig;
  logic last;

  // ==========================================
  // next state
  always_comb begin
    next_r = r;
    dig = r.digits[`ISR_LAST_DIGIT - r.pos[2:0]];
    last = r.is_idn ? (r.pos == 6'(IDN_LEN)) : (r.pos == 6'(`ISR_DIGITS));
    if (r.valid && rsp_ready) begin
      next_r.valid = 1'b0;
    end
    case (r.phase)
      ISR_FMT_IDLE: begin
        if (start) begin
          next_r.val = value;
          next_r.is_idn = is_idn;
          next_r.cnt = 3'h0;
          next_r.pos = 6'h00;
          next_r.lead = 1'b1;
          next_r.eoi = 1'b0;
          next_r.phase = is_idn ? ISR_FMT_SEND : ISR_FMT_CONV;
        end
      end
      ISR_FMT_CONV: begin
        next_r.digits[r.cnt] = 4'(r.val % 16'd10);
        next_r.val = r.val / 16'd10;
        next_r.cnt = r.cnt + 3'h1;
        if (r.cnt == `ISR_LAST_DIGIT) begin
          next_r.phase = ISR_FMT_SEND;
        end
      end
      ISR_FMT_SEND: begin
        if (!r.valid || rsp_ready) begin
          if (r.valid && r.eoi) begin
            next_r.eoi = 1'b0;
            next_r.phase = ISR_FMT_IDLE;
          end else if (last) begin
            next_r.data = `ISR_ASCII_NL;
            next_r.eoi = 1'b1;
            next_r.valid = 1'b1;
          end else if (r.is_idn) begin
            next_r.data = IDN_STR[8*(IDN_LEN-1-int'(r.pos)) +: 8];
            next_r.valid = 1'b1;
            next_r.pos = r.pos + 6'h01;
          end else begin
            // a zero value still sends its units digit
            if (!(dig == 4'h0 && r.lead && r.pos != 6'(`ISR_LAST_DIGIT))) begin
              next_r.data = `ISR_ASCII_ZERO | {4'h0, dig};
              next_r.valid = 1'b1;
              next_r.lead = 1'b0;
            end
            next_r.pos = r.pos + 6'h01;
          end
        end
      end
      default: next_r.phase = ISR_FMT_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign busy = (r.phase != ISR_FMT_IDLE);
  assign rsp_data = r.data;
  assign rsp_eoi = r.eoi && r.valid;
  assign rsp_valid = r.valid;

endmodule : isr_dec_fmt

// file: rtl/isr_status_top.sv
// Purpose: common command handling and status reporting of the remote interface
// Assumes: commands arrive parsed, one per handshake, from logic on SYS_CLK
// Notes: event register clears on its own query; set wins over clear
//
// Summary of operation
// - reset command pulses instrument reset
// - trigger measures, then result goes out
// - clear-status empties event register and disarms complete
// - identify returns five fields, newline end
// - self test returns error sum, zero clean
// - event enable mask loads and reads back
// - event bits: power, user, errors, control, complete
// - service request mask loads and reads back
// - status byte bits 7..4, low nibble zero
// - event query returns event register value
// - status byte query changes nothing
// - complete command sets bit after pending work
// - complete query sends one after pending work
`timescale 1ns/100ps
module isr_status_top
  import isr_pkg::*;
(
  input wire logic SYS_CLK, // 125 MHz system clock
  input wire logic NRST, // async reset, active low
  input wire logic CMD_VALID, // parsed command present
  input wire logic [3:0] CMD_CODE, // command code, isr_cmd_t
  input wire logic [7:0] CMD_ARG, // mask value for enable commands
  output logic CMD_READY, // command taken when high with valid
  input wire logic [6:1] EVENT_IN, // event pulses for event bits 6..1
  input wire logic OPER_SUMMARY, // operation status summary level
  input wire logic OPS_PENDING, // instrument has unfinished operations
  output logic INST_RESET, // one-cycle instrument reset pulse
  output logic MEAS_START, // one-cycle measurement start
  input wire logic MEAS_DONE, // measurement finished pulse
  input wire logic [15:0] MEAS_RESULT, // measurement result
  output logic TEST_START, // one-cycle self test start
  input wire logic TEST_DONE, // self test finished pulse
  input wire logic [15:0] TEST_ERRSUM, // sum of error codes
  output logic [7:0] STB_OUT, // status byte for serial poll
  output logic SRQ, // request service level
  output logic [7:0] RSP_DATA, // reply byte to output buffer
  output logic RSP_EOI, // end marker on last byte
  output logic RSP_VALID, // reply byte valid
  input wire logic RSP_READY // output buffer takes byte
);

  isr_top_t r;
  isr_top_t next_r;
  logic fmt_busy;
  logic accept;
  isr_cmd_t cmd;
  logic [7:0] esr_set;
  logic [7:0] esr_clr;
  logic [7:0] sb;

  assign cmd = isr_cmd_t'(CMD_CODE);
  // refuse commands while a reply or a wait is open, so no reply is lost
  assign CMD_READY = (r.state == ISR_ST_IDLE) && !fmt_busy && !r.fmt_start;
  assign accept = CMD_VALID && CMD_READY;

  // ==========================================
  // command sequencing
  always_comb begin
    next_r = r;
    next_r.inst_reset = 1'b0;
    next_r.meas_start = 1'b0;
    next_r.test_start = 1'b0;
    next_r.fmt_start = 1'b0;
    esr_set = {1'b0, EVENT_IN, 1'b0};
    esr_clr = 8'h00;
    if (r.opc_armed && !OPS_PENDING) begin
      esr_set[`ISR_ESR_OPC] = 1'b1;
      next_r.opc_armed = 1'b0;
    end
    case (r.state)
      ISR_ST_IDLE: begin
        if (accept) begin
          next_r.fmt_idn = 1'b0;
          case (cmd)
            ISR_CMD_RST: begin
              next_r.inst_reset = 1'b1;
              next_r.opc_armed = 1'b0;
            end
            ISR_CMD_TRG: begin
              next_r.meas_start = 1'b1;
              next_r.state = ISR_ST_MEAS;
            end
            ISR_CMD_IDN_Q: begin
              next_r.fmt_start = 1'b1;
              next_r.fmt_idn = 1'b1;
            end
            ISR_CMD_TST_Q: begin
              next_r.test_start = 1'b1;
              next_r.state = ISR_ST_TEST;
            end
            ISR_CMD_ESE: next_r.ese = CMD_ARG;
            ISR_CMD_ESE_Q: begin
              next_r.fmt_start = 1'b1;
              next_r.fmt_value = {8'h00, r.ese};
            end
            ISR_CMD_SRE: next_r.sre = CMD_ARG;
            ISR_CMD_SRE_Q: begin
              next_r.fmt_start = 1'b1;
              next_r.fmt_value = {8'h00, r.sre};
            end
            ISR_CMD_ESR_Q: begin
              next_r.fmt_start = 1'b1;
              next_r.fmt_value = {8'h00, r.esr};
              esr_clr = 8'hFF;
            end
            ISR_CMD_STB_Q: begin
              next_r.fmt_start = 1'b1;
              next_r.fmt_value = {8'h00, r.stb};
            end
            ISR_CMD_OPC: next_r.opc_armed = 1'b1;
            ISR_CMD_OPC_Q: next_r.state = ISR_ST_OPCQ;
            ISR_CMD_CLS: begin
              esr_clr = 8'hFF;
              next_r.opc_armed = 1'b0;
            end
            default: ;
          endcase
        end
      end
      ISR_ST_MEAS: begin
        if (MEAS_DONE) begin
          next_r.fmt_start = 1'b1;
          next_r.fmt_value = MEAS_RESULT;
          next_r.state = ISR_ST_IDLE;
        end
      end
      ISR_ST_TEST: begin
        if (TEST_DONE) begin
          next_r.fmt_start = 1'b1;
          next_r.fmt_value = TEST_ERRSUM;
          next_r.state = ISR_ST_IDLE;
        end
      end
      ISR_ST_OPCQ: begin
        if (!OPS_PENDING) begin
          next_r.fmt_start = 1'b1;
          next_r.fmt_value = `ISR_OPC_REPLY;
          next_r.state = ISR_ST_IDLE;
        end
      end
      default: next_r.state = ISR_ST_IDLE;
    endcase
    // an event in the clearing cycle survives the clear
    next_r.esr = (r.esr & ~esr_clr) | esr_set;
    sb = 8'h00;
    sb[`ISR_STB_OSS] = OPER_SUMMARY;
    sb[`ISR_STB_ESS] = |(next_r.esr & next_r.ese);
    sb[`ISR_STB_MAV] = fmt_busy || next_r.fmt_start;
    sb[`ISR_STB_RQS] = |(sb & next_r.sre);
    next_r.stb = sb;
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      r <= '0;
      r.state <= ISR_ST_IDLE;
      r.ese <= `ISR_ESE_RESET;
      r.sre <= `ISR_SRE_RESET;
      r.esr <= `ISR_ESR_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================
  // reply formatter
  isr_dec_fmt u_fmt (
    .clk(SYS_CLK),
    .nrst(NRST),
    .start(r.fmt_start),
    .is_idn(r.fmt_idn),
    .value(r.fmt_value),
    .busy(fmt_busy),
    .rsp_data(RSP_DATA),
    .rsp_eoi(RSP_EOI),
    .rsp_valid(RSP_VALID),
    .rsp_ready(RSP_READY)
  );

  assign INST_RESET = r.inst_reset;
  assign MEAS_START = r.meas_start;
  assign TEST_START = r.test_start;
  assign STB_OUT = r.stb;
  assign SRQ = r.stb[`ISR_STB_RQS];

  // ==========================================
  // checks
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);

  // a second reset command right behind the first legally stretches the pulse
  chk_rst_pulse: assert property (accept && cmd == ISR_CMD_RST |=> INST_RESET
    ##1 (!INST_RESET || $past(accept && cmd == ISR_CMD_RST)))
    else $error("reset command gave no single reset pulse");
  chk_trg_result: assert property (r.state == ISR_ST_MEAS && MEAS_DONE |=> r.fmt_start
    && r.fmt_value == $past(MEAS_RESULT) ##1 fmt_busy)
    else $error("measurement result not sent");
  // operation summary is not event status, so it may still request service after a clear
  chk_cls_clear: assert property (accept && cmd == ISR_CMD_CLS && EVENT_IN == 6'h00
    && !(r.opc_armed && !OPS_PENDING) |=> r.esr == 8'h00 && !STB_OUT[`ISR_STB_ESS]
    && SRQ == (STB_OUT[`ISR_STB_OSS] && r.sre[`ISR_STB_OSS]))
    else $error("clear status left bits set");
  chk_idn_start: assert property (accept && cmd == ISR_CMD_IDN_Q |=> r.fmt_start && r.fmt_idn)
    else $error("identify reply not started");
  chk_tst_zero: assert property (r.state == ISR_ST_TEST && TEST_DONE && TEST_ERRSUM == 16'h0000
    |=> r.fmt_start && r.fmt_value == 16'h0000)
    else $error("clean self test did not report zero");
  chk_ese_load: assert property (accept && cmd == ISR_CMD_ESE |=> r.ese == $past(CMD_ARG))
    else $error("event enable mask not loaded");
  chk_evt_bit: assert property (EVENT_IN[5] |=> r.esr[5])
    else $error("command error event not latched");
  chk_sre_load: assert property (accept && cmd == ISR_CMD_SRE |=> r.sre == $past(CMD_ARG))
    else $error("service request mask not loaded");
  chk_stb_low: assert property (STB_OUT[3:0] == 4'h0 && STB_OUT[7] == $past(OPER_SUMMARY))
    else $error("status byte layout wrong");
  chk_esr_query: assert property (accept && cmd == ISR_CMD_ESR_Q |=> r.fmt_value == {8'h00, $past(r.esr)})
    else $error("event query value wrong");
  chk_stb_keep: assert property (accept && cmd == ISR_CMD_STB_Q && EVENT_IN == 6'h00
    && !r.opc_armed && $stable(OPER_SUMMARY) |=> r.esr == $past(r.esr))
    else $error("status byte query changed state");
  chk_opc_set: assert property (r.opc_armed && !OPS_PENDING |=> r.esr[`ISR_ESR_OPC])
    else $error("operation complete bit not set");
  chk_opcq_wait: assert property (r.state == ISR_ST_OPCQ && OPS_PENDING |=> !r.fmt_start)
    else $error("complete query answered while pending");
  chk_opcq_one: assert property (r.state == ISR_ST_OPCQ && !OPS_PENDING
    |=> r.fmt_start && r.fmt_value == `ISR_OPC_REPLY)
    else $error("complete query reply wrong");
  chk_ess_sum: assert property (STB_OUT[`ISR_STB_ESS] == |(r.esr & r.ese))
    else $error("event summary bit wrong");
  chk_rqs_sum: assert property (SRQ == |({STB_OUT[7], 1'b0, STB_OUT[5:0]} & r.sre))
    else $error("request service bit wrong");

  cov_trigger: cover property (accept && cmd == ISR_CMD_TRG ##[1:1000] RSP_EOI && RSP_READY);
  cov_srq: cover property (accept && cmd == ISR_CMD_SRE ##[1:50] SRQ);
  cov_opcq: cover property (accept && cmd == ISR_CMD_OPC_Q ##[1:1000] RSP_VALID && RSP_DATA == 8'h31);

endmodule : isr_status_top

// file: test/isr_host_model.sv
// Purpose: reply sink standing in for the bus controller
// Assumes: one reply collected at a time, cleared before each command
// Notes: slow mode takes one byte in four cycles to stall the formatter
`timescale 1ns/100ps
module isr_host_model (
  input wire logic clk, // system clock
  input wire logic nrst, // reset, active low
  input wire logic slow, // stall the reply path
  input wire logic [7:0] rsp_data, // reply byte
  input wire logic rsp_eoi, // end marker
  input wire logic rsp_valid, // reply byte valid
  output logic rsp_ready = 1'b0 // byte taken
);
  // ==========================================
  // collection
  logic [7:0] got_q[$];
  logic done = 1'b0;
  logic [1:0] phase = 2'h0;

  task automatic clear_reply();
    got_q.delete();
    done = 1'b0;
  endtask : clear_reply

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rsp_ready <= 1'b0;
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
      rsp_ready <= !slow || (phase == 2'h3);
      if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
        got_q.push_back(rsp_data);
        if (rsp_eoi === 1'b1) begin
          done <= 1'b1;
        end
      end
    end
  end
endmodule : isr_host_model

// file: test/isr_status_top_tb.sv
// Purpose: self-checking bench of the status reporting block
// Assumes: isr_host_model collects replies
// Notes: replies are judged byte by byte, newline with end last
`timescale 1ns/100ps
module isr_status_top_tb import isr_pkg::*; ;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic cmd_valid = 1'b0;
  logic [3:0] cmd_code = 4'h0;
  logic [7:0] cmd_arg = 8'h00;
  logic [6:1] event_in = 6'h00;
  logic oper_summary = 1'b0;
  logic ops_pending = 1'b0;
  logic meas_done = 1'b0;
  logic [15:0] meas_result = 16'h0000;
  logic test_done = 1'b0;
  logic [15:0] test_errsum = 16'h0000;
  logic slow = 1'b0;
  logic cmd_ready, inst_reset, meas_start, test_start, srq, rsp_eoi, rsp_valid, rsp_ready;
  logic [7:0] stb_out, rsp_data;
  int mismatches = 0;
  int num_checks = 0;
  int n_rst = 0;
  int n_meas = 0;
  int n_test = 0;

  always #4 sys_clk = ~sys_clk;

  isr_status_top u_dut (.SYS_CLK(sys_clk), .NRST(nrst), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code),
    .CMD_ARG(cmd_arg), .CMD_READY(cmd_ready), .EVENT_IN(event_in), .OPER_SUMMARY(oper_summary),
    .OPS_PENDING(ops_pending), .INST_RESET(inst_reset), .MEAS_START(meas_start), .MEAS_DONE(meas_done),
    .MEAS_RESULT(meas_result), .TEST_START(test_start), .TEST_DONE(test_done), .TEST_ERRSUM(test_errsum),
    .STB_OUT(stb_out), .SRQ(srq), .RSP_DATA(rsp_data), .RSP_EOI(rsp_eoi), .RSP_VALID(rsp_valid),
    .RSP_READY(rsp_ready));

  isr_host_model u_host (.clk(sys_clk), .nrst(nrst), .slow(slow), .rsp_data(rsp_data), .rsp_eoi(rsp_eoi),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready));

  always @(posedge sys_clk) begin
    if (inst_reset === 1'b1) n_rst++;
    if (meas_start === 1'b1) n_meas++;
    if (test_start === 1'b1) n_test++;
  end

  // ==========================================
  // shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // request held until the edge at which ready is seen high
  task automatic send_cmd(input isr_cmd_t code, input logic [7:0] arg);
    int n;
    n = 0;
    u_host.clear_reply();
    cmd_valid <= 1'b1;
    cmd_code <= code;
    cmd_arg <= arg;
    @(negedge sys_clk);
    while (cmd_ready !== 1'b1 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    // a command never taken counts against the run
    check("command taken", {15'h0, cmd_ready}, 16'h0001);
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    @(posedge sys_clk);
  endtask : send_cmd

  task automatic wait_reply();
    int n;
    n = 0;
    while (u_host.done !== 1'b1 && n < 600) begin
      @(posedge sys_clk);
      n++;
    end
    check("reply end", {15'h0, u_host.done}, 16'h0001);
    @(posedge sys_clk);
  endtask : wait_reply

  task automatic expect_reply(input isr_cmd_t code, input logic [7:0] arg, input string s);
    send_cmd(code, arg);
    wait_reply();
    check("reply length", 16'(u_host.got_q.size()), 16'(s.len() + 1));
    foreach (u_host.got_q[i]) begin
      if (i < s.len()) check("reply byte", {8'h00, u_host.got_q[i]}, {8'h00, s[i]});
      else check("reply newline", {8'h00, u_host.got_q[i]}, 16'h000A);
    end
  endtask : expect_reply

  task automatic pulse_event(input int i);
    event_in <= 6'h01 << (i - 1);
    @(posedge sys_clk);
    event_in <= 6'h00;
    repeat (3) @(posedge sys_clk);
  endtask : pulse_event

  // ==========================================
  // scenarios
  task automatic t_reset();
    check("status byte", {8'h00, stb_out}, 16'h0000);
    expect_reply(ISR_CMD_ESE_Q, 8'h00, "0");
    expect_reply(ISR_CMD_SRE_Q, 8'h00, "0");
    expect_reply(ISR_CMD_ESR_Q, 8'h00, "128");
    expect_reply(ISR_CMD_ESR_Q, 8'h00, "0");
    $display("reset test done");
  endtask : t_reset

  task automatic t_events();
    for (int i = 1; i <= 6; i++) begin
      pulse_event(i);
      expect_reply(ISR_CMD_ESR_Q, 8'h00, $sformatf("%0d", 1 << i));
    end
    $display("event test done");
  endtask : t_events

  task automatic t_summary();
    send_cmd(ISR_CMD_ESE, 8'h24);
    pulse_event(5);
    check("status byte", {8'h00, stb_out}, 16'h0020);
    send_cmd(ISR_CMD_SRE, 8'h20);
    repeat (2) @(posedge sys_clk);
    check("status byte", {8'h00, stb_out}, 16'h0060);
    check("request", {15'h0, srq}, 16'h0001);
    oper_summary <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("status byte", {8'h00, stb_out}, 16'h00E0);
    // the byte is read before its own reply raises message available
    expect_reply(ISR_CMD_STB_Q, 8'h00, "224");
    check("status length", 16'(u_host.got_q.size()), 16'h0004);
    check("status kept", {8'h00, stb_out}, 16'h00E0);
    expect_reply(ISR_CMD_ESE_Q, 8'h00, "36");
    expect_reply(ISR_CMD_SRE_Q, 8'h00, "32");
    send_cmd(ISR_CMD_CLS, 8'h00);
    repeat (2) @(posedge sys_clk);
    check("status byte", {8'h00, stb_out}, 16'h0080);
    check("request", {15'h0, srq}, 16'h0000);
    expect_reply(ISR_CMD_ESR_Q, 8'h00, "0");
    oper_summary <= 1'b0;
    $display("summary test done");
  endtask : t_summary

  task automatic t_actions();
    send_cmd(ISR_CMD_RST, 8'h00);
    repeat (2) @(posedge sys_clk);
    check("reset pulses", 16'(n_rst), 16'h0001);
    slow <= 1'b1;
    send_cmd(ISR_CMD_TRG, 8'h00);
    repeat (2) @(posedge sys_clk);
    check("measure pulses", 16'(n_meas), 16'h0001);
    repeat (20) @(posedge sys_clk);
    meas_done <= 1'b1;
    meas_result <= 16'd12345;
    @(posedge sys_clk);
    meas_done <= 1'b0;
    wait_reply();
    check("result length", 16'(u_host.got_q.size()), 16'h0006);
    check("result first", {8'h00, u_host.got_q[0]}, 16'h0031);
    slow <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      test_errsum <= (k == 0) ? 16'd0 : 16'd300;
      u_host.clear_reply();
      fork
        send_cmd(ISR_CMD_TST_Q, 8'h00);
        begin
          repeat (12) @(posedge sys_clk);
          test_done <= 1'b1;
          @(posedge sys_clk);
          test_done <= 1'b0;
        end
      join
      wait_reply();
      check("test sum first", {8'h00, u_host.got_q[0]}, (k == 0) ? 16'h0030 : 16'h0033);
      check("test sum length", 16'(u_host.got_q.size()), (k == 0) ? 16'h0002 : 16'h0004);
    end
    check("test pulses", 16'(n_test), 16'h0002);
    expect_reply(ISR_CMD_IDN_Q, 8'h00, "MAKER0,MODEL0,FW0,HW0,DATE0");
    $display("action test done");
  endtask : t_actions

  task automatic t_complete();
    ops_pending <= 1'b1;
    send_cmd(ISR_CMD_OPC, 8'h00);
    repeat (20) @(posedge sys_clk);
    expect_reply(ISR_CMD_ESR_Q, 8'h00, "0");
    ops_pending <= 1'b0;
    repeat (3) @(posedge sys_clk);
    expect_reply(ISR_CMD_ESR_Q, 8'h00, "1");
    ops_pending <= 1'b1;
    send_cmd(ISR_CMD_OPC_Q, 8'h00);
    repeat (30) @(posedge sys_clk);
    check("early reply", 16'(u_host.got_q.size()), 16'h0000);
    ops_pending <= 1'b0;
    wait_reply();
    check("complete length", 16'(u_host.got_q.size()), 16'h0002);
    check("complete char", {8'h00, u_host.got_q[0]}, 16'd49);
    $display("complete test done");
  endtask : t_complete

  // ==========================================
  // run control
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_events();
    t_summary();
    t_actions();
    t_complete();
    give_verdict();
  end
endmodule : isr_status_top_tb
